// file: dps_pkg.sv
// Package for the dual-port static RAM port cycle controller.
// Assumes a single 100 MHz system clock; pin timing in ns is rounded up to whole cycles.
`default_nettype none
package dps_pkg;
  localparam int          DPS_ADDR_W      = 11;
  localparam int          DPS_DATA_W      = 8;
  localparam int          CLK_PERIOD_NS   = 10;
  // Pin timing figures in ns (slowest grade shown by default)
  localparam int          ADDR_SETUP_NS   = 0;
  localparam int          WRITE_PULSE_NS  = 65;
  localparam int          data_setup_to_write_end_NS = 40;
  localparam int          OUT_OFF_NS      = 50;
  localparam int          write_recovery_time_NS = 0;
  localparam int          READ_ACCESS_NS  = 120;
  localparam int          arbitration_flag_address_delay_NS = 60;
  // Least times round up; write recovery never below one cycle
  localparam int          WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int          OEWP_NS = OUT_OFF_NS
                                    + data_setup_to_write_end_NS;
  localparam int          OEWP_CYC = (OEWP_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int          RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int          WR_CYC_RAW = (write_recovery_time_NS
                                        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  localparam int          BAA_CYC = (arbitration_flag_address_delay_NS
                                     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          AS_CYC = 1;
  localparam logic [7:0]  CNT_ZERO = 8'h00;
  localparam logic [1:0]  PINS_IDLE = 2'h3;

  typedef enum logic [2:0] {
    DPS_IDLE, DPS_RSETUP, DPS_RACC, DPS_WSETUP, DPS_WPULSE, DPS_WREC
  } dps_state_e;

  // Request from the user side
  typedef struct packed {
    logic                    write;
    logic [DPS_ADDR_W-1:0]   addr;
    logic [DPS_DATA_W-1:0]   wdata;
  } dps_req_s;
endpackage
`default_nettype wire

// file: dps_port_ctrl.sv
// Host-side controller for one port of a dual-port static RAM.
// Assumes synchronous user requests; pins are driven from flip-flops.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Same controller serves left or right port; instantiate once per port.
// - Read/write line stays high for the whole read cycle.
// - Address is valid before or with chip select falling.
// - Read/write stays high whenever address lines change.
// - Master holds off its data while device outputs still drive.
// - With output enable low, write pulse covers turn-off plus data setup.
// - Master/slave width expansion stretches write cycle by flag delay.
module dps_port_ctrl
  import dps_pkg::*;
(
  input  wire logic                  sys_clk,    // 100 MHz clock
  input  wire logic                  reset,      // Async, active high
  input  wire logic                  clk_en,     // Freezes state when low
  input  wire logic                  req_valid,  // Start a cycle
  input  wire dps_req_s              req,        // Cycle request
  input  wire logic                  oe_during_wr, // Keep OE low in writes
  input  wire logic                  width_exp,  // Master/slave pair in use
  output logic                       req_ready,  // Idle, may accept
  output logic                       rd_valid,   // Read data pulse
  output logic [DPS_DATA_W-1:0]      rd_data,    // Captured read data
  output logic                       sel_n,      // Chip select, active low
  output logic                       rw,         // High read, low write
  output logic                       oe_n,       // Output enable, active low
  output logic [DPS_ADDR_W-1:0]      addr,       // Address pins
  input  wire logic [DPS_DATA_W-1:0] data_in,    // Data pins in
  output logic [DPS_DATA_W-1:0]      data_out,   // Data pins out
  output logic                       data_oe     // High while we drive data
);
  dps_state_e state;
  logic [7:0] cnt;
  logic       cur_oe;

  // Pulse length for the write: longer when OE stays low or expanded
  function automatic logic [7:0] wpulse(input logic oe_lo,
                                        input logic exp);
    int n;
    n = WP_CYC;
    if (oe_lo && OEWP_CYC > n)
      n = OEWP_CYC;
    if (exp)
      n = n + BAA_CYC;
    return n[7:0];
  endfunction

  // Main sequencer; select falls only after address settles
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state     <= DPS_IDLE;
      cnt       <= CNT_ZERO;
      cur_oe    <= 1'b0;
      req_ready <= 1'b0;
      sel_n     <= 1'b1;
      rw        <= 1'b1;
      oe_n      <= 1'b1;
      addr      <= '0;
      data_out  <= '0;
      data_oe   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      unique case (state)
        DPS_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            addr      <= req.addr;    // Address moves with rw high
            data_out  <= req.wdata;
            cur_oe    <= oe_during_wr;
            cnt       <= 8'(AS_CYC);
            state     <= req.write ? DPS_WSETUP : DPS_RSETUP;
          end
        end
        DPS_RSETUP: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) begin
            sel_n <= 1'b0;              // Address already stable
            oe_n  <= 1'b0;
            cnt   <= 8'(RD_CYC);
            state <= DPS_RACC;
          end
        end
        DPS_RACC: begin
          cnt <= cnt - 8'h01;           // rw held high throughout
          if (cnt == 8'h01) begin
            rd_data  <= data_in;        // Device drives while selected
            rd_valid <= 1'b1;
            sel_n    <= 1'b1;
            oe_n     <= 1'b1;
            cnt      <= 8'(WR_CYC);
            state    <= DPS_WREC;
          end
        end
        DPS_WSETUP: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) begin
            // rw and select fall together so outputs stay off
            rw    <= 1'b0;
            sel_n <= 1'b0;
            oe_n  <= ~cur_oe;
            cnt   <= wpulse(cur_oe, width_exp);
            state <= DPS_WPULSE;
          end
        end
        DPS_WPULSE: begin
          cnt <= cnt - 8'h01;
          // Drive data only once device outputs are off
          data_oe <= 1'b1;
          if (cnt == 8'h01) begin
            rw    <= 1'b1;              // First rising edge ends write
            sel_n <= 1'b1;
            oe_n  <= 1'b1;
            cnt   <= 8'(WR_CYC);
            state <= DPS_WREC;
          end
        end
        DPS_WREC: begin
          data_oe <= 1'b0;              // Data held one cycle past end
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01)
            state <= DPS_IDLE;
        end
        default: state <= DPS_IDLE;
      endcase
    end
  end

  // one instance per port, no shared state
  AST_RW_STABLE_ADDR: assert property (@(posedge sys_clk) disable iff (reset)
    addr != $past(addr) |-> rw && $past(rw))
    else $error("address moved while write low");
  AST_READ_RW_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
    state == DPS_RACC |-> rw)
    else $error("rw low during read");
  AST_SETUP_BEFORE_SEL: assert property (@(posedge sys_clk)
    disable iff (reset)
    $fell(sel_n) |-> $stable(addr))
    else $error("address changed with select");
  AST_WR_TOGETHER: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(rw) |-> $fell(sel_n))
    else $error("rw fell without select");
  AST_NO_DRIVE_READ: assert property (@(posedge sys_clk) disable iff (reset)
    data_oe |-> rw == 1'b0 || state == DPS_WREC)
    else $error("data driven outside write");
  AST_WR_END_BOTH: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(rw) |-> $rose(sel_n))
    else $error("write ended on one line only");
  AST_PULSE_MIN: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(rw) |-> !rw [*7])
    else $error("write pulse too short");
  AST_READ_DONE: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(sel_n) && rw |-> ##[1:20] rd_valid)
    else $error("read never finished");

  // OE held low in a write: pulse must outlast turn-off plus data setup.
  // Nine cycles is the stretched length at the slowest grade.
  AST_OE_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(rw) && !oe_n |-> !rw [*8] ##1 !rw)
    else $error("write pulse too short with output enable low");

  // OE left high in a plain write, so the short pulse is legal
  AST_OE_OFF_NO_OE: assert property (@(posedge sys_clk)
    disable iff (reset)
    !rw && !cur_oe |-> oe_n)
    else $error("output enable low in a short write");

  // Paired devices: pulse grows by the flag delay, thirteen cycles here with OE left high, fifteen with OE held low
  AST_EXP_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(rw) && width_exp |-> !rw [*8] ##1 !rw [*5])
    else $error("write cycle not stretched for width expansion");

  // Data pins stay released in the cycle the write opens, because the
  // device may still be turning its own drivers off
  AST_DATA_AFTER_OFF: assert property (@(posedge sys_clk)
    disable iff (reset)
    $fell(rw) |-> !data_oe)
    else $error("data driven as the write opened");

  // Ready only in idle, with the pins parked so the address may move
  AST_READY_IDLE: assert property (@(posedge sys_clk) disable iff (reset)
    req_ready |-> state == DPS_IDLE && sel_n && rw)
    else $error("ready outside idle");

  // Clock enable low must freeze the pins and the sequencer
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (reset)
    !clk_en |=> $stable(sel_n) && $stable(rw) && $stable(addr)
                && $stable(state))
    else $error("state moved while clock enable low");

  // Coverage of the main transfer kinds
  COV_READ: cover property (@(posedge sys_clk) rd_valid);
  COV_WRITE: cover property (@(posedge sys_clk) $rose(rw));
  COV_WRITE_OE: cover property (@(posedge sys_clk)
    !rw && !oe_n);
  COV_WRITE_EXP: cover property (@(posedge sys_clk)
    $fell(rw) && width_exp);
endmodule
`default_nettype wire

// file: dps_ram_model.sv
// Behavioural device model for one port of the dual-port static RAM.
// Assumes the host pins come from flip-flops clocked by sys_clk.
`timescale 1ns/10ps
`default_nettype none
module dps_ram_model
  import dps_pkg::*;
(
  input  wire logic                  sys_clk,  // Sampling clock
  input  wire logic                  sel_n,    // Chip select, active low
  input  wire logic                  rw,       // High read, low write
  input  wire logic                  oe_n,     // Output enable, active low
  input  wire logic [DPS_ADDR_W-1:0] addr,     // Address pins
  input  wire logic [DPS_DATA_W-1:0] data_out, // Host write data
  input  wire logic                  data_oe,  // Host drives data
  output logic [DPS_DATA_W-1:0]      data_in,  // Data seen by host
  output int                         plen,     // Last write pulse cycles
  output int                         viol      // Host misbehaviour count
);
  logic [DPS_DATA_W-1:0] mem [2**DPS_ADDR_W];
  logic [DPS_DATA_W-1:0] last = '0;
  logic [DPS_ADDR_W-1:0] pa = '0;
  logic                  drv;
  int                    run = 0;
  // Drive only when selected, enabled and reading; otherwise released
  assign drv = !sel_n && !oe_n && rw;
  // A released bus shows the inverse so a stale value never matches
  assign data_in = drv ? mem[addr] : ~last;
  initial begin
    plen = 0;
    viol = 0;
  end
  // Write during the select/write overlap; pulse ends at first rise
  always @(posedge sys_clk) begin
    pa <= addr;
    if (drv) last <= mem[addr];
    if (!sel_n && !rw) begin
      mem[addr] <= data_out;
      run <= run + 1;
    end else if (run != 0) begin
      plen <= run;
      run <= 0;
    end
    if (!rw && addr != pa) viol <= viol + 1;
    if (drv && data_oe) viol <= viol + 1;
  end
endmodule
`default_nettype wire

// file: dual_port_sram_port_cycles_tb.sv
// Self-checking bench: one port controller against the RAM model.
// Assumes the package timing constants; clock enable is dropped only in the freeze test.
`timescale 1ns/10ps
`default_nettype none
module dual_port_sram_port_cycles_tb;
  import dps_pkg::*;
  logic                  sys_clk = 0;
  logic                  reset = 1;
  logic                  req_valid = 0;
  logic                  clk_en = 1;
  logic                  oe_during_wr = 0;
  logic                  width_exp = 0;
  dps_req_s              req = '0;
  logic                  req_ready, rd_valid, sel_n, rw, oe_n, data_oe;
  logic [DPS_DATA_W-1:0] rd_data, data_in, data_out;
  logic [DPS_ADDR_W-1:0] addr;
  int                    plen, viol, failures = 0, check_count = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  dps_port_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .oe_during_wr(oe_during_wr),
    .width_exp(width_exp), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .sel_n(sel_n), .rw(rw), .oe_n(oe_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  dps_ram_model u_ram (.sys_clk(sys_clk), .sel_n(sel_n), .rw(rw),
    .oe_n(oe_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .plen(plen), .viol(viol));
  task automatic end_of_test;
    $display("failures %0d check_count %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t data %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  // Hold the request until the edge that takes it, then drop it
  task automatic issue(input logic w, input logic [10:0] a, logic [7:0] d);
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    req_valid = 1;
    req = '{write: w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    req_valid = 0;
  endtask
  task automatic do_read(input logic [10:0] a, input logic [7:0] e);
    issue(0, a, 8'h00);
    for (int i = 0; i < 40 && rd_valid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_data(rd_data, e);
  endtask
  // Every pulse-length mode, then every word read back
  task automatic t_pulse_modes;
    int p;
    for (int m = 0; m < 4; m++) begin
      oe_during_wr = m[0];
      width_exp = m[1];
      issue(1, 11'(m * 16'h0155), 8'(8'hA5 ^ m));
      p = (m[0] && OEWP_CYC > WP_CYC) ? OEWP_CYC : WP_CYC;
      issue(0, 11'h001, 8'h00);
      chk_cnt(plen, p + (m[1] ? BAA_CYC : 0));
    end
    for (int m = 0; m < 4; m++)
      do_read(11'(m * 16'h0155), 8'(8'hA5 ^ m));
  endtask
  // Freeze in mid read, then a reset in mid write
  task automatic t_freeze;
    issue(1, 11'h0F0, 8'h5A);
    issue(0, 11'h0F0, 8'h00);
    @(posedge sys_clk);
    #1 clk_en = 0;
    repeat (6) @(posedge sys_clk);
    #1 chk_cnt(int'({sel_n, rd_valid}), 0);
    clk_en = 1;
    for (int i = 0; i < 40 && rd_valid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_data(rd_data, 8'h5A);
    issue(1, 11'h0F1, 8'h66);
    repeat (3) @(posedge sys_clk);
    #1 reset = 1;
    @(posedge sys_clk);
    #1 chk_cnt(int'({sel_n, rw, oe_n, data_oe, req_ready}), 28);
    reset = 0;
    do_read(11'h0F0, 8'h5A);
  endtask
  // Boundary addresses back to back, then host pin discipline
  task automatic t_edges;
    issue(1, 11'h7FF, 8'h3C);
    issue(1, 11'h000, 8'hC3);
    do_read(11'h7FF, 8'h3C);
    do_read(11'h000, 8'hC3);
    chk_cnt(viol, 0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 reset = 0;
    t_pulse_modes();
    t_edges();
    t_freeze();
    end_of_test();
  end
endmodule
`default_nettype wire
